// File: design/tiop_params.svh
// constants for the timed i/o port: widths, counts and reset values
`ifndef TIOP_PARAMS_SVH
`define TIOP_PARAMS_SVH
`define TIOP_CB_COUNT 6
`define TIOP_CB_SEL_W 3
`define TIOP_CB_DIV_W 8
`define TIOP_CNT_W 16
`define TIOP_XFER_W 32
`define TIOP_PORT_W 4
`define TIOP_FIFO_DEPTH 8
`define TIOP_REF_CB 3'h0
`define TIOP_RST_DIV 8'h00
`define TIOP_RST_CNT 16'h0000
`endif

// File: design/tiop_pkg.sv
// types shared by the timed i/o port modules
package tiop_pkg;
  typedef enum logic [1:0] {
    TIOP_IDLE,
    TIOP_WAIT,
    TIOP_SHIFT
  } tiop_fsm_type;
  typedef enum logic [1:0] {
    TIOP_COND_NONE,
    TIOP_COND_EQ,
    TIOP_COND_NE
  } tiop_cond_type;
endpackage

// File: design/tiop_fifo.sv
// parameterised fifo between the core and the serializer
`timescale 1ns/1ps
module tiop_fifo #(
  parameter int WIDTH = 49,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic in_ready;
    logic out_valid;
  } tiop_fifo_state_type;
  tiop_fifo_state_type s, next_s;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("tiop_fifo depth must be a power of two, at least 2");
  end

  assign push = ce & in_valid & s.in_ready & ~flush;
  assign pop = ce & out_ready & s.out_valid & ~flush;
  assign in_ready = s.in_ready;
  assign out_valid = s.out_valid;
  assign out_data = mem[s.rptr];

  always_comb begin
    next_s = s;
    if (flush & ce) begin
      next_s.wptr = '0;
      next_s.rptr = '0;
      next_s.count = '0;
    end else begin
      if (push) begin
        next_s.wptr = s.wptr + 1'b1;
      end
      if (pop) begin
        next_s.rptr = s.rptr + 1'b1;
      end
      if (push & ~pop) begin
        next_s.count = s.count + 1'b1;
      end else if (pop & ~push) begin
        next_s.count = s.count - 1'b1;
      end
    end
    next_s.in_ready = next_s.count != (AW+1)'(DEPTH);
    next_s.out_valid = next_s.count != '0;
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '{wptr: '0, rptr: '0, count: '0, in_ready: 1'b1,
             out_valid: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[s.wptr] <= in_data;
    end
  end
endmodule

// File: design/tiop_port.sv
// timed i/o port with clock blocks, serializer, counter and pin muxing
`timescale 1ns/1ps
`include "tiop_params.svh"
module tiop_port #(
  parameter int WIDTH = `TIOP_PORT_W,
  parameter int XFER_W = `TIOP_XFER_W,
  parameter int DEPTH = `TIOP_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic cfg_write,
  input wire logic cfg_dir_out,
  input wire logic cfg_open_drain,
  input wire logic [`TIOP_CB_SEL_W-1:0] cfg_clk_sel,
  input wire logic [1:0] cfg_cond_mode,
  input wire logic [WIDTH-1:0] cfg_cond_value,
  input wire logic cfg_strobe_in_en,
  input wire logic cfg_strobe_out_en,
  input wire logic cfg_time_en,
  input wire logic [`TIOP_CNT_W-1:0] cfg_time,
  input wire logic cb_write,
  input wire logic [`TIOP_CB_SEL_W-1:0] cb_index,
  input wire logic cb_from_pin,
  input wire logic [`TIOP_CB_DIV_W-1:0] cb_div,
  input wire logic link_en,
  input wire logic [WIDTH-1:0] narrow_taken,
  input wire logic clk_pin_in,
  input wire logic strobe_in,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic pin_pull_down,
  output logic output_strobe,
  input wire logic core_wr_valid,
  input wire logic [XFER_W-1:0] core_wr_data,
  input wire logic core_wr_time_en,
  input wire logic [`TIOP_CNT_W-1:0] core_wr_time,
  output logic core_wr_ready,
  output logic core_rd_valid,
  output logic [XFER_W-1:0] core_rd_data,
  input wire logic core_rd_ready,
  output logic [`TIOP_CNT_W-1:0] port_count,
  output logic [`TIOP_CNT_W-1:0] stamp,
  output logic pin_event
);
  localparam int NCB = `TIOP_CB_COUNT;
  localparam int CNTW = `TIOP_CNT_W;
  localparam int NCH = XFER_W / WIDTH;
  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;
  localparam int FW = XFER_W + CNTW + 1;

  typedef struct packed {
    logic dir_out;
    logic open_drain;
    logic [`TIOP_CB_SEL_W-1:0] clk_sel;
    tiop_pkg::tiop_cond_type cond;
    logic [WIDTH-1:0] cond_val;
    logic sin_en;
    logic sout_en;
    logic tin_en;
    logic [CNTW-1:0] tin;
    logic [NCB-1:0] cb_pin;
    logic [NCB-1:0][`TIOP_CB_DIV_W-1:0] cb_div;
    logic [NCB-1:0][`TIOP_CB_DIV_W-1:0] cb_cnt;
    logic clk_pin_prev;
    logic [CNTW-1:0] count;
    tiop_pkg::tiop_fsm_type fsm;
    logic [XFER_W-1:0] shreg;
    logic [CW-1:0] chunk;
    logic [CNTW-1:0] wait_time;
    logic [WIDTH-1:0] out_val;
    logic [WIDTH-1:0] pin_out;
    logic [WIDTH-1:0] pin_oe;
    logic pull_down;
    logic out_strobe;
    logic rd_valid;
    logic [XFER_W-1:0] rd_data;
    logic [CNTW-1:0] stamp;
    logic evt;
  } tiop_state_type;

  tiop_state_type s, next_s;
  logic [NCB-1:0] cb_tick;
  logic tick, qual, cond_ok, drive_now, at_time, last;
  logic fifo_flush, fifo_in_valid, fifo_in_ready;
  logic fifo_out_valid, fifo_out_ready;
  logic [FW-1:0] fifo_in_data, fifo_out_data;
  logic [XFER_W-1:0] shifted_in;
  logic [WIDTH-1:0] avail;

  if (!(WIDTH == 1 || WIDTH == 4 || WIDTH == 8 || WIDTH == 16 ||
        WIDTH == 32) || (XFER_W % WIDTH) != 0 || XFER_W > 32) begin : g_chk
    $error("tiop_port width must be 1/4/8/16/32 and divide XFER_W");
  end

  tiop_fifo #(
    .WIDTH(FW),
    .DEPTH(DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ce(ce),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_data(fifo_in_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_out_ready)
  );

  // clock block ticks; block 0 follows ref_clk, others divide ref or pin
  always_comb begin
    for (int i = 0; i < NCB; i++) begin
      cb_tick[i] = (~s.cb_pin[i] | (clk_pin_in & ~s.clk_pin_prev)) &
                   (s.cb_cnt[i] == s.cb_div[i]);
    end
  end

  assign tick = cb_tick[s.clk_sel];
  assign at_time = s.count == s.wait_time;
  assign last = s.chunk == CW'(NCH - 1);
  assign shifted_in = (NCH > 1) ?
      {pin_in, s.shreg[XFER_W-1:WIDTH]} : XFER_W'(pin_in);
  assign qual = tick & (~s.sin_en | strobe_in) & fifo_in_ready;
  assign drive_now = s.dir_out & tick &
      ((s.fsm == tiop_pkg::TIOP_SHIFT) |
       ((s.fsm == tiop_pkg::TIOP_WAIT) & at_time));
  assign avail = ~narrow_taken & {WIDTH{~link_en}};

  always_comb begin
    case (s.cond)
      tiop_pkg::TIOP_COND_EQ: cond_ok = pin_in == s.cond_val;
      tiop_pkg::TIOP_COND_NE: cond_ok = pin_in != s.cond_val;
      default: cond_ok = 1'b1;
    endcase
  end

  // fifo carries core words out, or sampled words
  assign fifo_flush = cfg_write & (cfg_dir_out != s.dir_out);
  assign fifo_in_valid = s.dir_out ? core_wr_valid :
      (~s.dir_out & qual & last &
       ((s.fsm == tiop_pkg::TIOP_SHIFT) |
        ((s.fsm == tiop_pkg::TIOP_IDLE) & ~s.tin_en & cond_ok) |
        ((s.fsm == tiop_pkg::TIOP_WAIT) & at_time)));
  assign fifo_in_data = s.dir_out ?
      {core_wr_time_en, core_wr_time, core_wr_data} :
      {1'b0, CNTW'(0), shifted_in};
  assign fifo_out_ready = s.dir_out ? (s.fsm == tiop_pkg::TIOP_IDLE) :
      (~s.rd_valid | core_rd_ready);

  always_comb begin
    next_s = s;
    next_s.pull_down = 1'b0;
    next_s.evt = 1'b0;
    next_s.clk_pin_prev = clk_pin_in;
    for (int i = 1; i < NCB; i++) begin
      if (~s.cb_pin[i] | (clk_pin_in & ~s.clk_pin_prev)) begin
        next_s.cb_cnt[i] = cb_tick[i] ? '0 : s.cb_cnt[i] + 1'b1;
      end
    end
    if (cb_write && cb_index != '0 && int'(cb_index) < NCB) begin
      next_s.cb_pin[cb_index] = cb_from_pin;
      next_s.cb_div[cb_index] = cb_div;
      next_s.cb_cnt[cb_index] = '0;
    end
    if (tick) begin
      next_s.count = s.count + 1'b1;
      next_s.out_strobe = drive_now & s.sout_en;
    end
    if (s.dir_out) begin
      if (s.fsm == tiop_pkg::TIOP_IDLE && fifo_out_valid) begin
        next_s.shreg = fifo_out_data[XFER_W-1:0];
        next_s.wait_time = fifo_out_data[FW-2:XFER_W];
        next_s.chunk = '0;
        next_s.fsm = fifo_out_data[FW-1] ?
            tiop_pkg::TIOP_WAIT : tiop_pkg::TIOP_SHIFT;
      end
      if (drive_now) begin
        next_s.out_val = s.shreg[WIDTH-1:0];
        next_s.shreg = (NCH > 1) ? (s.shreg >> WIDTH) : s.shreg;
        next_s.chunk = s.chunk + 1'b1;
        if (s.chunk == '0) begin
          next_s.stamp = s.count;
        end
        if (last) begin
          next_s.fsm = tiop_pkg::TIOP_IDLE;
        end else begin
          next_s.fsm = tiop_pkg::TIOP_SHIFT;
        end
      end
    end else begin
      case (s.fsm)
        tiop_pkg::TIOP_IDLE: begin
          if (s.tin_en) begin
            next_s.tin_en = 1'b0;
            next_s.wait_time = s.tin;
            next_s.fsm = tiop_pkg::TIOP_WAIT;
          end else if (qual && cond_ok) begin
            next_s.evt = s.cond != tiop_pkg::TIOP_COND_NONE;
            next_s.stamp = s.count;
            next_s.shreg = shifted_in;
            next_s.chunk = CW'(1);
            next_s.fsm = last ? tiop_pkg::TIOP_IDLE : tiop_pkg::TIOP_SHIFT;
          end
        end
        tiop_pkg::TIOP_WAIT: begin
          if (qual && at_time) begin
            next_s.stamp = s.count;
            next_s.shreg = shifted_in;
            next_s.chunk = CW'(1);
            next_s.fsm = last ? tiop_pkg::TIOP_IDLE : tiop_pkg::TIOP_SHIFT;
          end
        end
        tiop_pkg::TIOP_SHIFT: begin
          if (qual) begin
            next_s.shreg = shifted_in;
            next_s.chunk = s.chunk + 1'b1;
            if (last) begin
              next_s.fsm = tiop_pkg::TIOP_IDLE;
            end
          end
        end
        default: next_s.fsm = tiop_pkg::TIOP_IDLE;
      endcase
    end
    // core read register: one handshake per cycle
    if (~s.dir_out && fifo_out_valid && (~s.rd_valid || core_rd_ready)) begin
      next_s.rd_valid = 1'b1;
      next_s.rd_data = fifo_out_data[XFER_W-1:0];
    end else if (core_rd_ready) begin
      next_s.rd_valid = 1'b0;
    end
    if (cfg_write) begin
      next_s.dir_out = cfg_dir_out;
      next_s.open_drain = cfg_open_drain;
      next_s.clk_sel = (int'(cfg_clk_sel) < NCB) ? cfg_clk_sel : s.clk_sel;
      next_s.cond = tiop_pkg::tiop_cond_type'(cfg_cond_mode);
      next_s.cond_val = cfg_cond_value;
      next_s.sin_en = cfg_strobe_in_en;
      next_s.sout_en = cfg_strobe_out_en;
      next_s.tin_en = cfg_time_en & ~cfg_dir_out;
      next_s.tin = cfg_time;
      if (cfg_dir_out != s.dir_out) begin
        next_s.fsm = tiop_pkg::TIOP_IDLE;
        next_s.chunk = '0;
        next_s.rd_valid = 1'b0;
      end
    end
    next_s.pin_out = s.open_drain ? '0 : s.out_val;
    next_s.pin_oe = avail & {WIDTH{s.dir_out}} &
        (s.open_drain ? ~s.out_val : {WIDTH{1'b1}});
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.clk_sel <= `TIOP_REF_CB;
      s.count <= `TIOP_RST_CNT;
      s.cb_div <= {NCB{`TIOP_RST_DIV}};
      s.pull_down <= 1'b1;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign pin_out = s.pin_out;
  assign pin_oe = s.pin_oe;
  assign pin_pull_down = s.pull_down;
  assign output_strobe = s.out_strobe;
  assign core_wr_ready = fifo_in_ready;
  assign core_rd_valid = s.rd_valid;
  assign core_rd_data = s.rd_data;
  assign port_count = s.count;
  assign stamp = s.stamp;
  assign pin_event = s.evt;
endmodule

// File: bench/tiop_port_assertions.sv
// concurrent checks on the timed i/o port outputs
`timescale 1ns/1ps
module tiop_port_checker #(
  parameter int WIDTH = 4
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic cfg_write,
  input wire logic cfg_dir_out,
  input wire logic cfg_open_drain,
  input wire logic [2:0] cfg_clk_sel,
  input wire logic [1:0] cfg_cond_mode,
  input wire logic cfg_strobe_out_en,
  input wire logic ce,
  input wire logic link_en,
  input wire logic [WIDTH-1:0] narrow_taken,
  input wire logic [WIDTH-1:0] pin_out,
  input wire logic [WIDTH-1:0] pin_oe,
  input wire logic pin_pull_down,
  input wire logic output_strobe,
  input wire logic [15:0] port_count,
  input wire logic pin_event
);
  logic od, dout, sout, ref_sel, no_cond;
  // shadow of the loaded configuration
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      od <= 1'h0;
      dout <= 1'h0;
      sout <= 1'h0;
      ref_sel <= 1'h1;
      no_cond <= 1'h1;
    end else if (cfg_write && ce) begin
      od <= cfg_open_drain;
      dout <= cfg_dir_out;
      sout <= cfg_strobe_out_en;
      no_cond <= cfg_cond_mode == 2'h0;
      if (cfg_clk_sel < 3'h6) ref_sel <= cfg_clk_sel == 3'h0;
    end
  end
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  pull_release_a: assert property ($past(reset_n) |-> !pin_pull_down)
    else $error("pull-down on after reset");
  link_off_a: assert property (
    link_en && $past(link_en) |-> pin_oe == '0)
    else $error("pin driven while link enabled");
  narrow_off_a: assert property (
    (pin_oe & narrow_taken & $past(narrow_taken)) == '0)
    else $error("pin driven while taken by narrower port");
  count_step_a: assert property (port_count - $past(port_count) <= 16'h1)
    else $error("counter jumped");
  ref_rate_a: assert property ($past(ref_sel) && $past(ce) && $past(reset_n, 2)
    |-> port_count == $past(port_count) + 16'h1)
    else $error("counter not ticking on block 0");
  in_quiet_a: assert property (!dout && !$past(dout) && !$past(dout, 2)
    |-> pin_oe == '0)
    else $error("input port drives pins");
  od_low_a: assert property (
    od && $past(od) && $past(od, 2) |-> pin_out == '0)
    else $error("open drain drives high");
  strobe_off_a: assert property (!sout && !$past(sout) |-> !output_strobe)
    else $error("strobe while disabled");
  event_off_a: assert property (no_cond && $past(no_cond) |-> !pin_event)
    else $error("event without condition");
endmodule
bind tiop_port tiop_port_checker #(.WIDTH(WIDTH)) tiop_port_checker_inst (
  .ref_clk(ref_clk), .reset_n(reset_n), .cfg_write(cfg_write),
  .cfg_dir_out(cfg_dir_out), .cfg_open_drain(cfg_open_drain),
  .cfg_clk_sel(cfg_clk_sel), .cfg_cond_mode(cfg_cond_mode),
  .cfg_strobe_out_en(cfg_strobe_out_en), .ce(ce), .link_en(link_en),
  .narrow_taken(narrow_taken), .pin_out(pin_out), .pin_oe(pin_oe),
  .pin_pull_down(pin_pull_down), .output_strobe(output_strobe),
  .port_count(port_count), .pin_event(pin_event)
);

// File: bench/tiop_pins_model.sv
// far-side pins: data source and application clock pin
`timescale 1ns/1ps
module tiop_pins_model (
  input wire logic ref_clk,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] ext_val,
  input wire logic ext_en,
  input wire logic clk_run,
  output logic [3:0] pin_in,
  output logic clk_pin_in
);
  logic [3:0] last = 4'h0;
  initial clk_pin_in = 1'h0;
  // pin clock stands still unless a burst is running
  always @(posedge ref_clk) begin
    if (clk_run) clk_pin_in <= ~clk_pin_in;
    last <= pin_in;
  end
  // undriven lines show ext_val while ext_en is set, otherwise the inverse of their last level
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en ? ext_val[i] : ~last[i];
    end
  end
endmodule

// File: bench/tiop_port_bench.sv
// self-checking bench for the timed i/o port
`timescale 1ns/1ps
module tiop_port_bench;
  logic ref_clk = '0, reset_n = '0, ce = '1, cfg_write = '0, dir = '0;
  logic od = '0, sen = '0, cb_write = '0, cb_pin = '0, link = '0;
  logic sin = '0, xen = '0, run = '0, wv = '0, wten = '0, rd_ready = '0;
  logic wr_ready, rd_valid, clk_pin, pd, ostb, evt;
  logic [2:0] sel = '0, cbi = '0;
  logic [3:0] narrow = '0, xval = '0, pin_in, pin_out, pin_oe;
  logic [7:0] div = '0;
  logic [15:0] wtime = '0, cnt, stamp;
  logic [31:0] wd = '0, rd_data;
  int failures = 0, n_compared = 0;
  tiop_port tiop_port_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .cfg_write(cfg_write),
    .cfg_dir_out(dir), .cfg_open_drain(od), .cfg_clk_sel(sel),
    .cfg_cond_mode(2'h0), .cfg_cond_value(4'h0), .cfg_strobe_in_en(sen),
    .cfg_strobe_out_en(sen), .cfg_time_en(1'h0), .cfg_time(16'h0000),
    .cb_write(cb_write), .cb_index(cbi), .cb_from_pin(cb_pin), .cb_div(div),
    .link_en(link), .narrow_taken(narrow), .clk_pin_in(clk_pin),
    .strobe_in(sin), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pull_down(pd), .output_strobe(ostb), .core_wr_valid(wv),
    .core_wr_data(wd), .core_wr_time_en(wten), .core_wr_time(wtime),
    .core_wr_ready(wr_ready), .core_rd_valid(rd_valid),
    .core_rd_data(rd_data), .core_rd_ready(rd_ready), .port_count(cnt),
    .stamp(stamp), .pin_event(evt)
  );
  tiop_pins_model tiop_pins_model_inst (
    .ref_clk(ref_clk), .pin_out(pin_out), .pin_oe(pin_oe), .ext_val(xval),
    .ext_en(xen), .clk_run(run), .pin_in(pin_in), .clk_pin_in(clk_pin)
  );
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic results();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cfg(input logic d, o, input logic [2:0] s, input logic e);
    @(negedge ref_clk);
    dir = d;
    od = o;
    sel = s;
    sen = e;
    cfg_write = 1'h1;
    @(negedge ref_clk);
    cfg_write = 1'h0;
  endtask
  task automatic cb(input logic [2:0] i, input logic p, input logic [7:0] d);
    @(negedge ref_clk);
    cbi = i;
    cb_pin = p;
    div = d;
    cb_write = 1'h1;
    @(negedge ref_clk);
    cb_write = 1'h0;
  endtask
  task automatic t_reset();
    logic [15:0] c0;
    repeat (10) @(negedge ref_clk);
    chk(pd, 1'h1);
    chk(pin_oe, 4'h0);
    chk(cnt, 16'h0000);
    reset_n = 1'h1;
    repeat (2) @(negedge ref_clk);
    chk(pd, 1'h0);
    c0 = cnt;
    repeat (16) @(negedge ref_clk);
    chk(cnt - c0, 16'h0010);
    // clock enable low must freeze the counter
    ce = 1'h0;
    c0 = cnt;
    repeat (5) @(negedge ref_clk);
    chk(cnt, c0);
    ce = 1'h1;
    $display("reset test done");
  endtask
  task automatic t_out(input logic o);
    logic [15:0] t;
    logic [3:0] c;
    logic seen;
    int k;
    cfg(1'h1, o, 3'h0, ~o);
    t = cnt + 16'h0014;
    wtime = t;
    wten = 1'h1;
    wd = 32'hFEDCBA98;
    wv = 1'h1;
    @(negedge ref_clk);
    chk(wr_ready, 1'h1);
    wv = 1'h0;
    wten = 1'h0;
    seen = 1'h0;
    for (k = 0; k < 40; k++) begin
      if (pin_out === (o ? 4'h0 : 4'h8) && pin_oe === (o ? 4'h7 : 4'hF)) break;
      @(negedge ref_clk);
    end
    chk(k < 40, 1'h1);
    if (k == 40) results();
    for (k = 0; k < 9; k++) begin
      c = 4'h8 + k[3:0];
      seen |= ostb;
      if (k < 8) chk(pin_out, o ? 4'h0 : c);
      if (k < 8) chk(pin_oe, o ? (c ^ 4'hF) : 4'hF);
      @(negedge ref_clk);
    end
    chk(seen, !o);
    chk(stamp, t);
    $display("output test done");
  endtask
  task automatic t_mux();
    cfg(1'h1, 1'h0, 3'h0, 1'h0);
    link = 1'h1;
    repeat (3) @(negedge ref_clk);
    chk(pin_oe, 4'h0);
    link = 1'h0;
    narrow = 4'h3;
    repeat (3) @(negedge ref_clk);
    chk(pin_oe & 4'h3, 4'h0);
    chk(pin_oe, 4'hC);
    narrow = 4'h0;
    $display("pin sharing test done");
  endtask
  task automatic t_in();
    int c;
    cfg(1'h0, 1'h0, 3'h0, 1'h1);
    xen = 1'h1;
    // output enables drop one cycle after the direction change
    @(negedge ref_clk);
    for (c = 0; c < 8; c++) begin
      if (c == 4) begin
        sin = 1'h0;
        xval = 4'hF;
        @(negedge ref_clk);
      end
      xval = c[3:0] + 4'h3;
      sin = 1'h1;
      @(negedge ref_clk);
    end
    sin = 1'h0;
    rd_ready = 1'h1;
    for (c = 0; c < 20 && rd_valid !== 1'h1; c++) @(negedge ref_clk);
    chk(rd_data, 32'hA9876543);
    if (c == 20) results();
    @(negedge ref_clk);
    rd_ready = 1'h0;
    $display("input test done");
  endtask
  task automatic t_fill();
    int n;
    cb(3'h1, 1'h0, 8'hFF);
    cfg(1'h1, 1'h0, 3'h1, 1'h0);
    wv = 1'h1;
    n = 0;
    repeat (12) begin
      if (wr_ready === 1'h1) n++;
      @(negedge ref_clk);
    end
    wv = 1'h0;
    chk(n == 8 || n == 9, 1'h1);
    chk(wr_ready, 1'h0);
    cfg(1'h0, 1'h0, 3'h1, 1'h0);
    repeat (3) @(negedge ref_clk);
    chk(wr_ready, 1'h1);
    $display("buffer test done");
  endtask
  task automatic t_cb();
    logic [15:0] c0;
    cb(3'h1, 1'h0, 8'h03);
    repeat (3) @(negedge ref_clk);
    c0 = cnt;
    repeat (40) @(negedge ref_clk);
    chk(cnt - c0, 16'h000A);
    cb(3'h2, 1'h1, 8'h01);
    cfg(1'h0, 1'h0, 3'h2, 1'h0);
    repeat (4) @(negedge ref_clk);
    c0 = cnt;
    run = 1'h1;
    repeat (20) @(negedge ref_clk);
    run = 1'h0;
    repeat (6) @(negedge ref_clk);
    chk(cnt - c0, 16'h0005);
    cfg(1'h0, 1'h0, 3'h0, 1'h0);
    $display("clock block test done");
  endtask
  initial begin
    t_reset();
    t_out(1'h0);
    t_out(1'h1);
    t_mux();
    t_in();
    t_fill();
    t_cb();
    results();
  end
endmodule
